// [dv/clock_power_mode_control_test.sv]
// self-checking bench for the clock and power-mode control block
// assumes a 100 MHz sys_clk and synchronous active-high reset
`timescale 1ns/1ns
module clock_power_mode_control_test;
   import clkpm_pkg::*;
   logic sys_clk = 1'h0, rst = 1'h1, ctrlWr = 1'h0, sleepReq = 1'h0, keyIrqFactor = 1'h0;
   logic [CTRL_W-1:0] ctrlWrMask = 5'h00, ctrlWrData = 5'h00, ctrl, expc;
   logic sel, fen, lcd, mon, rsel, slowRun, fastRun, asleep, sg, fg, busy, slowClk, fastClk, stable;
   logic [31:0] r = 32'h85850455; // random state
   int n_fail = 0, check_count = 0, i;
   assign ctrl = {rsel, mon, lcd, fen, sel};
   // ===========================
   // clock
   always #5 sys_clk = ~sys_clk;
   clock_power_mode_control DUT (.sys_clk(sys_clk), .rst(rst), .ctrlWr(ctrlWr), .ctrlWrMask(ctrlWrMask),
      .ctrlWrData(ctrlWrData), .sleepReq(sleepReq), .keyIrqFactor(keyIrqFactor), .cpuClockSelect_q(sel),
      .fastOscEnable_q(fen), .lcdSupplyEnable_q(lcd), .supplyMonitorEnable_q(mon),
      .regulatorSourceSelect_q(rsel), .slowOscRun_q(slowRun), .fastOscRun_q(fastRun), .asleep_q(asleep),
      .cpuSlowGate_q(sg), .cpuFastGate_q(fg), .clkSwitchBusy_q(busy));
   osc_model OSC (.sys_clk(sys_clk), .rst(rst), .slowRun(slowRun), .fastRun(fastRun), .slowClk(slowClk),
      .fastClk(fastClk), .fastStable(stable));
   // ===========================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [4:0] merge(input logic [4:0] c, m, d);
      return (c & ~m) | (d & m); // masked bits take new values
   endfunction
   task automatic finish_test();
      if (n_fail == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // inputs move 1 ns after the rising edge
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] m, input logic [4:0] d);
      ctrlWr = 1'h1;
      ctrlWrMask = m;
      ctrlWrData = d;
      step();
      ctrlWr = 1'h0;
   endtask
   // ===========================
   // main sequence
   initial begin
      repeat (3) step();
      rst = 1'h0;
      chk(sel, 1'h0);
      chk(fen, 1'h0);
      chk(lcd, 1'h0);
      chk(mon, 1'h0);
      chk({slowRun, fastRun, asleep, sg, fg}, 5'h12);
      // random masked writes, strobe dropped now and then
      expc = 5'h00;
      for (i = 0; i < 60; i++) begin
         r = lfsr(r);
         ctrlWr = r[0];
         ctrlWrMask = r[5:1];
         ctrlWrData = r[10:6];
         if (r[0]) expc = merge(expc, r[5:1], r[10:6]);
         step();
         chk(ctrl, expc);
      end
      wr(5'h1F, 5'h00);
      repeat (4) step();
      // select fast with oscillator off: stays on slow
      wr(5'h01, 5'h01);
      repeat (3) step();
      chk({sg, fg}, 2'h2);
      wr(5'h01, 5'h00);
      step();
      wr(5'h02, 5'h02);
      for (i = 0; i < 200 && stable !== 1'h1; i++) step();
      if (i == 200) begin
         n_fail++;
         finish_test();
      end
      wr(5'h01, 5'h01);
      chk(sel, 1'h1);
      step();
      chk({sg, fg, busy}, 3'h1);
      step();
      chk({sg, fg}, 2'h0);
      step();
      chk({sg, fg, busy}, 3'h2);
      wr(5'h01, 5'h00); // select slow first, disable fast later
      repeat (3) step();
      chk({sg, fg}, 2'h2);
      wr(5'h02, 5'h00);
      chk(fastRun, 1'h0);
      step();
      // sleep on slow clock with fast enabled
      wr(5'h02, 5'h02);
      sleepReq = 1'h1;
      step();
      sleepReq = 1'h0;
      chk({asleep, slowRun, fastRun, sg, fg}, 5'h10);
      wr(5'h1F, 5'h1C);
      sleepReq = 1'h1;
      repeat (3) step();
      sleepReq = 1'h0;
      chk({asleep, ctrl}, 6'h22);
      chk({slowClk, fastClk}, 2'h0);
      keyIrqFactor = 1'h1;
      step();
      keyIrqFactor = 1'h0;
      chk({asleep, slowRun, fastRun}, 3'h3);
      step();
      step();
      chk({sg, fg}, 2'h2);
      // boosted supply on, let it settle (shortened), then route the regulator to it
      wr(5'h04, 5'h04);
      repeat (8) step();
      wr(5'h10, 5'h10);
      chk({rsel, lcd}, 2'h3);
      step();
      // idle: cpu on the slow clock and the fast oscillator off
      wr(5'h1F, 5'h0C);
      chk({ctrl, fastRun}, 6'h18);
      finish_test();
   end
endmodule

// [dv/osc_model.sv]
// behavioural model of the slow and fast oscillator circuits
// assumes the run enables come from the power-mode block on sys_clk
`timescale 1ns/1ns
module osc_model #(
   parameter int SETTLE = 40 // fast start-up, shortened from the millisecond range
) (
   input wire logic sys_clk, // system clock
   input wire logic rst,     // synchronous reset
   input wire logic slowRun, // slow oscillator enabled
   input wire logic fastRun, // fast oscillator enabled
   output logic slowClk,     // slow oscillator output
   output logic fastClk,     // fast oscillator output
   output logic fastStable   // fast oscillation has settled
);
   int cnt; // cycles since the fast oscillator was started
   // ===========================
   // oscillators: a stopped one stands still at 0
   always_ff @(posedge sys_clk) begin
      slowClk <= slowRun & ~slowClk & ~rst;
      fastClk <= fastRun & ~fastClk & ~rst;
   end
   // settling: software must not select the fast clock before this rises
   always_ff @(posedge sys_clk) begin
      if (rst | ~fastRun) begin
         cnt <= 0;
      end else if (cnt < SETTLE) begin
         cnt <= cnt + 1;
      end
   end
   assign fastStable = (cnt == SETTLE);
endmodule

// [src/clk_switch.sv]
// break-before-make switch of the cpu clock between two oscillators
// assumes both oscillator clocks are gated by enables that this module drives
`timescale 1ns/1ns
module clk_switch (
   input wire logic sys_clk,    // system clock
   input wire logic rst,        // synchronous reset, active high
   input wire logic selFast,    // 1 asks for the fast clock
   input wire logic fastReady,  // fast oscillator is running
   input wire logic hold,       // sleep: both gates forced off
   output logic slowGate_q,     // slow clock reaches the cpu
   output logic fastGate_q,     // fast clock reaches the cpu
   output logic busy_q          // switch in progress
);
   import clkpm_pkg::*;

   // ==========================================================
   // state and dead-time counter
   sw_state_t st_q; // current switch state
   sw_state_t st_d; // next switch state
   logic [GAP_CNT_W-1:0] gap_q; // dead-time cycles counted
   logic gapDone; // dead time elapsed

   assign gapDone = (gap_q == GAP_CNT_W'(SWITCH_GAP_CYCLES - 1));

   // next state: never open one gate before the other has been closed for the gap
   always_comb begin
      st_d = st_q;
      if (!hold) begin
         case (st_q)
            SW_ON_SLOW: begin
               if (selFast && fastReady) st_d = SW_GAP_TO_FAST;
            end
            SW_GAP_TO_FAST: begin
               // a withdrawn request or a stopped oscillator turns back before the fast gate opens
               if (!selFast || !fastReady) st_d = SW_GAP_TO_SLOW;
               else if (gapDone) st_d = SW_ON_FAST;
            end
            SW_ON_FAST: begin
               // a stopped fast oscillator also falls back to slow
               if (!selFast || !fastReady) st_d = SW_GAP_TO_SLOW;
            end
            SW_GAP_TO_SLOW: begin
               if (gapDone) st_d = SW_ON_SLOW;
            end
            default: st_d = SW_ON_SLOW;
         endcase
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (rst) st_q <= SW_ON_SLOW;
      else st_q <= st_d;
   end

   // dead-time counter, restarts on entry to a gap state
   always_ff @(posedge sys_clk) begin
      if (rst) gap_q <= '0;
      else if (st_d != st_q) gap_q <= '0;
      else if (!hold && (st_q == SW_GAP_TO_FAST || st_q == SW_GAP_TO_SLOW)) gap_q <= gap_q + 1'b1;
   end

   // gates come from the next state so they change on the same edge as the state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slowGate_q <= 1'b1;
         fastGate_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         slowGate_q <= (st_d == SW_ON_SLOW) && !hold;
         fastGate_q <= (st_d == SW_ON_FAST) && !hold;
         busy_q <= (st_d == SW_GAP_TO_FAST) || (st_d == SW_GAP_TO_SLOW);
      end
   end

endmodule

// [src/clkpm_pkg.sv]
// package of constants for the clock and power-mode control block
// assumes a single 100 MHz system clock and a synchronous active-high reset
package clkpm_pkg;

   // ==========================================================
   // control word layout (one write strobe, per-bit mask)
   localparam int CTRL_W = 5;                 // number of control bits
   localparam int BIT_CPU_CLK_SEL = 0;        // cpu clock select position
   localparam int BIT_FAST_OSC_EN = 1;        // fast oscillator enable position
   localparam int BIT_LCD_SUPPLY_EN = 2;      // lcd supply enable position
   localparam int BIT_SUPPLY_MON_EN = 3;      // supply monitor enable position
   localparam int BIT_REG_SRC_SEL = 4;        // regulator source select position

   // ==========================================================
   // reset values
   localparam logic CPU_CLK_SEL_RST = 1'h0;   // slow oscillator after reset
   localparam logic FAST_OSC_EN_RST = 1'h0;   // fast oscillator stopped
   localparam logic LCD_SUPPLY_EN_RST = 1'h0; // lcd supply circuit off
   localparam logic SUPPLY_MON_EN_RST = 1'h0; // supply monitor off
   localparam logic REG_SRC_SEL_RST = 1'h0;   // regulator on default source
   localparam logic SLOW_OSC_RUN_RST = 1'h1;  // slow oscillator runs from reset

   // ==========================================================
   // timing
   localparam int SYS_CLK_MHZ = 100;          // system clock rate
   localparam int SWITCH_GAP_NS = 20;         // dead time between clock gates
   localparam int SWITCH_GAP_CYCLES = (SWITCH_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int GAP_CNT_W = 2;              // width of dead-time counter

   // ==========================================================
   // power-mode states, gray along awake -> sleep -> wake
   typedef enum logic [1:0] {
      PM_AWAKE = 2'h0,
      PM_SLEEP = 2'h1,
      PM_WAKE = 2'h3
   } pm_state_t;

   // clock switch states, gray around the loop
   typedef enum logic [1:0] {
      SW_ON_SLOW = 2'h0,
      SW_GAP_TO_FAST = 2'h1,
      SW_ON_FAST = 2'h3,
      SW_GAP_TO_SLOW = 2'h2
   } sw_state_t;

endpackage

// [src/clock_power_mode_control.sv]
// clock, oscillator and supply power-mode control with sleep handling
// assumes control writes come from the cpu as one-cycle strobes on sys_clk
`timescale 1ns/1ns
module clock_power_mode_control (
   input wire logic sys_clk,                              // system clock, 100 MHz
   input wire logic rst,                                  // synchronous reset, active high
   input wire logic ctrlWr,                               // control write strobe
   input wire logic [clkpm_pkg::CTRL_W-1:0] ctrlWrMask,   // bits to update
   input wire logic [clkpm_pkg::CTRL_W-1:0] ctrlWrData,   // new bit values
   input wire logic sleepReq,                             // sleep instruction executed
   input wire logic keyIrqFactor,                         // key input interrupt factor raised
   output logic cpuClockSelect_q,                         // 0 slow, 1 fast
   output logic fastOscEnable_q,                          // fast oscillator enable
   output logic lcdSupplyEnable_q,                        // lcd supply circuit on
   output logic supplyMonitorEnable_q,                    // supply voltage detector on
   output logic regulatorSourceSelect_q,                  // 1 boosted supply, 0 default
   output logic slowOscRun_q,                             // slow oscillator runs
   output logic fastOscRun_q,                             // fast oscillator runs
   output logic asleep_q,                                 // device in sleep
   output logic cpuSlowGate_q,                            // slow clock reaches cpu
   output logic cpuFastGate_q,                            // fast clock reaches cpu
   output logic clkSwitchBusy_q                           // clock switch in progress
);
   import clkpm_pkg::*;

   // ==========================================================
   // power-mode state
   pm_state_t pm_q; // current power mode
   pm_state_t pm_d; // next power mode
   logic ctrlWrOk; // write accepted (cpu running)
   logic fastEn_d; // next fast oscillator enable

   // writes while asleep cannot come from a halted cpu, so they are dropped
   assign ctrlWrOk = ctrlWr && (pm_q == PM_AWAKE);
   assign fastEn_d = (ctrlWrOk && ctrlWrMask[BIT_FAST_OSC_EN]) ? ctrlWrData[BIT_FAST_OSC_EN] : fastOscEnable_q;

   // next power mode; sleep is left on a key factor and nothing else
   always_comb begin
      pm_d = pm_q;
      case (pm_q)
         PM_AWAKE: begin
            if (sleepReq) pm_d = PM_SLEEP;
         end
         PM_SLEEP: begin
            if (keyIrqFactor) pm_d = PM_WAKE;
         end
         PM_WAKE: begin
            pm_d = PM_AWAKE; // one cycle for oscillators to restart
         end
         default: pm_d = PM_AWAKE;
      endcase
   end

   // power-mode register
   always_ff @(posedge sys_clk) begin
      if (rst) pm_q <= PM_AWAKE;
      else pm_q <= pm_d;
   end

   // ==========================================================
   // control bits, each written only where its mask bit is set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpuClockSelect_q <= CPU_CLK_SEL_RST;
         fastOscEnable_q <= FAST_OSC_EN_RST;
         lcdSupplyEnable_q <= LCD_SUPPLY_EN_RST;
         supplyMonitorEnable_q <= SUPPLY_MON_EN_RST;
         regulatorSourceSelect_q <= REG_SRC_SEL_RST;
      end else if (ctrlWrOk) begin
         if (ctrlWrMask[BIT_CPU_CLK_SEL]) cpuClockSelect_q <= ctrlWrData[BIT_CPU_CLK_SEL];
         if (ctrlWrMask[BIT_FAST_OSC_EN]) fastOscEnable_q <= ctrlWrData[BIT_FAST_OSC_EN];
         if (ctrlWrMask[BIT_LCD_SUPPLY_EN]) lcdSupplyEnable_q <= ctrlWrData[BIT_LCD_SUPPLY_EN];
         if (ctrlWrMask[BIT_SUPPLY_MON_EN]) supplyMonitorEnable_q <= ctrlWrData[BIT_SUPPLY_MON_EN];
         // the regulator source follows this bit directly; settling is software's duty
         if (ctrlWrMask[BIT_REG_SRC_SEL]) regulatorSourceSelect_q <= ctrlWrData[BIT_REG_SRC_SEL];
      end
   end

   // ==========================================================
   // oscillator run controls, registered from the next mode so sleep cuts them at once
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         slowOscRun_q <= SLOW_OSC_RUN_RST;
         fastOscRun_q <= FAST_OSC_EN_RST;
         asleep_q <= 1'b0;
      end else begin
         slowOscRun_q <= (pm_d != PM_SLEEP);
         fastOscRun_q <= fastEn_d && (pm_d != PM_SLEEP);
         asleep_q <= (pm_d == PM_SLEEP);
      end
   end

   // ==========================================================
   // glitch-free cpu clock switch; hold keeps both gates shut while asleep
   // limitation: if software sleeps on the fast clock the cpu still resumes
   // on fast once awake, which is why it should select slow first
   clk_switch u_clk_switch (
      .sys_clk(sys_clk),
      .rst(rst),
      .selFast(cpuClockSelect_q),
      .fastReady(fastOscRun_q),
      // hold follows the next mode, so the gates shut on the sleep edge itself
      .hold(pm_d != PM_AWAKE),
      .slowGate_q(cpuSlowGate_q),
      .fastGate_q(cpuFastGate_q),
      .busy_q(clkSwitchBusy_q)
   );

   // ==========================================================
   // checks
   a_reset_clk_sel: assert property (@(posedge sys_clk) rst |=> !cpuClockSelect_q && cpuSlowGate_q)
      else $error("cpu clock select not slow after reset");
   a_reset_fast_osc: assert property (@(posedge sys_clk) rst |=> !fastOscEnable_q && !fastOscRun_q)
      else $error("fast oscillator not off after reset");
   a_reset_lcd_supply: assert property (@(posedge sys_clk) rst |=> !lcdSupplyEnable_q)
      else $error("lcd supply not off after reset");
   a_reset_supply_mon: assert property (@(posedge sys_clk) rst |=> !supplyMonitorEnable_q)
      else $error("supply monitor not off after reset");
   a_sleep_stops_osc: assert property (@(posedge sys_clk) disable iff (rst)
      (pm_q == PM_AWAKE && sleepReq) |=> asleep_q && !slowOscRun_q && !fastOscRun_q && !cpuSlowGate_q)
      else $error("oscillators still running in sleep");
   a_wake_only_key: assert property (@(posedge sys_clk) disable iff (rst)
      (asleep_q && !keyIrqFactor) |=> asleep_q && !slowOscRun_q)
      else $error("sleep left without key factor");
   a_wake_on_key: assert property (@(posedge sys_clk) disable iff (rst)
      (asleep_q && keyIrqFactor) |=> !asleep_q && slowOscRun_q)
      else $error("key factor did not end sleep");
   a_reg_src_write: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrlWr && ctrlWrMask[BIT_REG_SRC_SEL] && !asleep_q && pm_q == PM_AWAKE)
      |=> regulatorSourceSelect_q == $past(ctrlWrData[BIT_REG_SRC_SEL]))
      else $error("regulator source select not updated");
   a_gates_exclusive: assert property (@(posedge sys_clk) disable iff (rst) !(cpuSlowGate_q && cpuFastGate_q))
      else $error("both clock gates open");
   a_gap_after_slow: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(cpuSlowGate_q) |-> !cpuFastGate_q [*2])
      else $error("fast gate opened without dead time");
   a_fast_gate_sel: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(cpuFastGate_q) |-> $past(cpuClockSelect_q) && $past(fastOscRun_q))
      else $error("fast gate opened without selection");

   // ==========================================================
   // further checks: reset values not covered above
   // regulator source starts on its default supply
   a_reset_reg_src: assert property (@(posedge sys_clk) rst |=> !regulatorSourceSelect_q)
      else $error("regulator source select not default after reset");
   // slow oscillator runs, no sleep, no switch and no fast clock out of reset
   a_reset_run_state: assert property (@(posedge sys_clk) rst |=>
      slowOscRun_q && !asleep_q && !cpuFastGate_q && !clkSwitchBusy_q)
      else $error("run state not idle after reset");

   // ==========================================================
   // further checks: each control bit takes its masked write one cycle later
   // a write only counts while awake; the wake cycle drops it as well
   a_sel_write: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrlWrOk && ctrlWrMask[BIT_CPU_CLK_SEL]) |=> cpuClockSelect_q == $past(ctrlWrData[BIT_CPU_CLK_SEL]))
      else $error("cpu clock select not updated");
   // fast oscillator enable
   a_fast_en_write: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrlWrOk && ctrlWrMask[BIT_FAST_OSC_EN]) |=> fastOscEnable_q == $past(ctrlWrData[BIT_FAST_OSC_EN]))
      else $error("fast oscillator enable not updated");
   // lcd supply enable
   a_lcd_write: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrlWrOk && ctrlWrMask[BIT_LCD_SUPPLY_EN]) |=> lcdSupplyEnable_q == $past(ctrlWrData[BIT_LCD_SUPPLY_EN]))
      else $error("lcd supply enable not updated");
   // supply monitor enable
   a_mon_write: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrlWrOk && ctrlWrMask[BIT_SUPPLY_MON_EN]) |=> supplyMonitorEnable_q == $past(ctrlWrData[BIT_SUPPLY_MON_EN]))
      else $error("supply monitor enable not updated");
   // writes in sleep or in the wake cycle leave every control bit alone
   a_write_dropped: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrlWr && pm_q != PM_AWAKE) |=> $stable({cpuClockSelect_q, fastOscEnable_q, lcdSupplyEnable_q,
      supplyMonitorEnable_q, regulatorSourceSelect_q}))
      else $error("control bits changed while asleep");

   // ==========================================================
   // further checks: oscillator runs and gates in sleep and wake
   // slow oscillator runs exactly while not asleep, the wake cycle included
   a_slow_run_match: assert property (@(posedge sys_clk) disable iff (rst)
      slowOscRun_q == !asleep_q)
      else $error("slow oscillator run does not follow sleep");
   // fast oscillator runs exactly when enabled and not asleep, the wake cycle included
   a_fast_run_match: assert property (@(posedge sys_clk) disable iff (rst)
      fastOscRun_q == (fastOscEnable_q && !asleep_q))
      else $error("fast oscillator run does not follow enable");
   // no clock reaches the halted cpu
   a_sleep_gates_shut: assert property (@(posedge sys_clk) disable iff (rst)
      asleep_q |-> !cpuSlowGate_q && !cpuFastGate_q)
      else $error("clock gate open in sleep");
   // gates stay shut in the wake cycle while the oscillators restart
   a_wake_gates_shut: assert property (@(posedge sys_clk) disable iff (rst)
      (pm_q == PM_WAKE) |-> !cpuSlowGate_q && !cpuFastGate_q)
      else $error("clock gate open in wake cycle");
   // sleep is entered only on a sleep request
   a_sleep_needs_req: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(asleep_q) |-> $past(sleepReq))
      else $error("sleep entered without request");
   // leaving sleep always passes through exactly one wake cycle
   a_wake_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(asleep_q) |-> pm_q == PM_WAKE ##1 pm_q == PM_AWAKE)
      else $error("wake cycle missing or too long");

   // ==========================================================
   // further checks: clock switch
   // the slow gate waits the dead time after the fast gate closes
   a_gap_after_fast: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(cpuFastGate_q) |-> !cpuSlowGate_q [*2])
      else $error("slow gate opened without dead time");
   // during the dead time no clock reaches the cpu
   a_busy_gates_shut: assert property (@(posedge sys_clk) disable iff (rst)
      clkSwitchBusy_q |-> !cpuSlowGate_q && !cpuFastGate_q)
      else $error("clock gate open during switch");
   // an awake cpu outside a switch always has one clock
   a_awake_has_clock: assert property (@(posedge sys_clk) disable iff (rst)
      (pm_q == PM_AWAKE && !clkSwitchBusy_q) |-> (cpuSlowGate_q || cpuFastGate_q))
      else $error("awake cpu without clock");
   // an awake slow gate only closes for a requested, running fast clock
   a_slow_fell_sel: assert property (@(posedge sys_clk) disable iff (rst)
      ($fell(cpuSlowGate_q) && !asleep_q) |-> $past(cpuClockSelect_q) && $past(fastOscRun_q))
      else $error("slow gate closed without selection");

endmodule
